// >>> src/bcp_pkg.sv
// Constants and types shared by the bus-control port configuration block.
`default_nettype none
package bcp_pkg;
  typedef enum logic [2:0] {
    BCP_NSC, BCP_NXN, BCP_NXW, BCP_SSC, BCP_SXN, BCP_SXW, BCP_PER
  } bcp_mode_t;

  localparam int          ADDR_W       = 10;
  localparam logic [7:0]  IDX_DIR      = 8'h09;
  localparam logic [7:0]  IDX_ASSIGN   = 8'h0A;
  localparam logic [7:0]  IDX_PULL     = 8'h0C;
  localparam logic [7:0]  IDX_DRIVE    = 8'h0D;

  localparam int          BIT_DATA_EN_OFF = 7;
  localparam int          BIT_PIPE        = 5;
  localparam int          BIT_CLK_PIN_OFF = 4;
  localparam int          BIT_STROBE_EN   = 3;
  localparam int          BIT_RW_EN       = 2;
  localparam int          BIT_CTL_PULL    = 4;
  localparam int          BIT_LOW_PULL    = 1;
  localparam int          BIT_HIGH_PULL   = 0;
  localparam int          BIT_CTL_WEAK    = 3;
  localparam int          BIT_LOW_WEAK    = 1;
  localparam int          BIT_HIGH_WEAK   = 0;

  localparam logic [7:0]  DIR_MASK     = 8'hFC;
  localparam logic [7:0]  ASSIGN_MASK  = 8'hBC;
  localparam logic [7:0]  PULL_MASK    = 8'h13;
  localparam logic [7:0]  DRIVE_MASK   = 8'h0B;
  localparam logic [7:0]  PULL_PINS    = 8'h8D;
  localparam logic [7:0]  PULL_ALWAYS  = 8'h02;

  localparam logic [7:0]  DIR_RST      = 8'h00;
  localparam logic [7:0]  ASSIGN_RST_NX  = 8'h00;
  localparam logic [7:0]  ASSIGN_RST_SP  = 8'h2C;
  localparam logic [7:0]  ASSIGN_RST_SCP = 8'h90;
  localparam logic [7:0]  PULL_RST     = 8'h10;
  localparam logic [7:0]  DRIVE_RST    = 8'h00;

  localparam logic [1:0]  RESP_OKAY    = 2'b00;
  localparam logic [1:0]  RESP_DECERR  = 2'b11;
endpackage : bcp_pkg
`default_nettype wire

// >>> src/bcp_port_config.sv
// Bus-control port configuration registers, pin steering and AXI4-Lite slave.
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module bcp_port_config
  import bcp_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              ce,
  input  wire bcp_mode_t         mode,
  input  wire logic              portEmulation,
  input  wire logic              internalVisibility,
  input  wire logic              busClockStretch,
  input  wire logic              tagEnable,
  input  wire logic [7:0]        gpioData,
  input  wire logic              dataBusEnableOut,
  input  wire logic [1:0]        queueState,
  input  wire logic              busClock,
  input  wire logic              lowByteStrobe,
  input  wire logic              rwSignal,
  input  wire logic [7:0]        pinIn,
  output logic [7:0]             pinOut,
  output logic [7:0]             pinOe,
  output logic [7:0]             pinPullup,
  output logic [7:0]             pinLevel,
  output logic                   lowBusPortPullup,
  output logic                   highBusPortPullup,
  output logic                   ctlPortWeakDrive,
  output logic                   lowBusPortWeakDrive,
  output logic                   highBusPortWeakDrive,
  output logic                   lowByteTag,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  output logic [1:0]             s_axi_bresp,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp
);
  logic              initDone_r;
  logic [7:0]        dir_r;
  logic [7:0]        assign_r;
  logic [7:0]        pull_r;
  logic [7:0]        drive_r;
  logic              assignWritten_r;
  logic              driveWritten_r;
  logic [7:0]        pinMeta_r;
  logic [7:0]        pinLevel_r;
  logic              busClockPrev_r;
  logic              lowByteTag_r;
  logic              awHeld_r;
  logic              wHeld_r;
  logic [ADDR_W-1:0] awAddr_r;
  logic [7:0]        wData_r;
  logic              wStrb0_r;
  logic              awready_r;
  logic              wready_r;
  logic              bvalid_r;
  logic [1:0]        bresp_r;
  logic              arready_r;
  logic              rvalid_r;
  logic [31:0]       rdata_r;
  logic [1:0]        rresp_r;
  logic [7:0]        pinOut_r;
  logic [7:0]        pinOe_r;
  logic [7:0]        pinPullup_r;
  logic              lowBusPull_r;
  logic              highBusPull_r;

  // Mode decode.
  wire isSingle  = (mode == BCP_NSC) || (mode == BCP_SSC);
  wire isPeriph  = (mode == BCP_PER);
  wire isSpecial = (mode == BCP_SSC) || (mode == BCP_SXN) || (mode == BCP_SXW);
  wire isExp     = !isSingle && !isPeriph;
  wire isNarrowN = (mode == BCP_NXN);

  // Mode-dependent reset value of the assignment register.
  wire [7:0] assignRstVal = (mode == BCP_NXN || mode == BCP_NXW) ? ASSIGN_RST_NX :
                            isSpecial ? ASSIGN_RST_SP : ASSIGN_RST_SCP;

  // Register presence in the internal map.
  wire dirMapped    = !isPeriph && !(isExp && portEmulation);
  wire assignMapped = !isPeriph;
  wire otherMapped  = !isPeriph;

  // Write channel bookkeeping.
  wire awTake  = s_axi_awvalid && awready_r;
  wire wTake   = s_axi_wvalid && wready_r;
  wire doWrite = awHeld_r && wHeld_r && !bvalid_r;
  wire awHeldNxt = (awHeld_r || awTake) && !doWrite;
  wire wHeldNxt  = (wHeld_r || wTake) && !doWrite;
  wire [7:0] wrIdx = awAddr_r[ADDR_W-1:2];
  wire wrDirHit    = (wrIdx == IDX_DIR) && dirMapped;
  wire wrAssignHit = (wrIdx == IDX_ASSIGN) && assignMapped;
  wire wrPullHit   = (wrIdx == IDX_PULL) && otherMapped;
  wire wrDriveHit  = (wrIdx == IDX_DRIVE) && otherMapped;
  wire wrHit       = wrDirHit || wrAssignHit || wrPullHit || wrDriveHit;
  wire wrLane      = doWrite && wStrb0_r;
  wire wrDir       = wrLane && wrDirHit;
  wire wrAssign    = wrLane && wrAssignHit;
  wire wrPull      = wrLane && wrPullHit;
  wire wrDrive     = wrLane && wrDriveHit;

  // Guarded bits take a write only on the permitted occasion.
  wire assignTake = isSpecial ? assignWritten_r : !assignWritten_r;
  wire driveTake  = isSpecial ? driveWritten_r : !driveWritten_r;
  wire neclkTake  = (mode == BCP_SSC) || ((mode == BCP_NSC) && !assignWritten_r);
  wire [7:0] wd   = wData_r;
  wire [7:0] assignWrVal = {
    wd[BIT_DATA_EN_OFF],
    1'b0,
    assignTake ? wd[BIT_PIPE] : assign_r[BIT_PIPE],
    isExp ? 1'b0 : (neclkTake ? wd[BIT_CLK_PIN_OFF] : assign_r[BIT_CLK_PIN_OFF]),
    assignTake ? wd[BIT_STROBE_EN] : assign_r[BIT_STROBE_EN],
    assignTake ? wd[BIT_RW_EN] : assign_r[BIT_RW_EN],
    2'b00
  } & ASSIGN_MASK;
  wire [7:0] driveWrVal = driveTake ? (wd & DRIVE_MASK) : drive_r;

  // Read channel.
  wire arTake = s_axi_arvalid && arready_r;
  wire rvalidNxt = arTake || (rvalid_r && !s_axi_rready);
  wire [7:0] rdIdx = s_axi_araddr[ADDR_W-1:2];
  wire rdDirHit    = (rdIdx == IDX_DIR) && dirMapped;
  wire rdAssignHit = (rdIdx == IDX_ASSIGN) && assignMapped;
  wire rdPullHit   = (rdIdx == IDX_PULL) && otherMapped;
  wire rdDriveHit  = (rdIdx == IDX_DRIVE) && otherMapped;
  wire rdHit       = rdDirHit || rdAssignHit || rdPullHit || rdDriveHit;
  wire [7:0] rdByte = rdDirHit ? (dir_r & DIR_MASK) :
                      rdAssignHit ? assign_r :
                      rdPullHit ? pull_r :
                      rdDriveHit ? drive_r : 8'h00;

  // Alternate function selection per pin.
  wire pipeAct  = assign_r[BIT_PIPE] && !isSingle;
  wire eclkAct   = !assign_r[BIT_CLK_PIN_OFF] &&
                   (!isSingle || internalVisibility || !busClockStretch);
  wire strobeAct = assign_r[BIT_STROBE_EN] && !isSingle && !isNarrowN;
  wire rwAct     = assign_r[BIT_RW_EN] && !isSingle;
  wire dataEnAct = !assign_r[BIT_DATA_EN_OFF];
  wire [7:0] altSel = {dataEnAct, pipeAct, pipeAct, eclkAct, strobeAct, rwAct, 2'b00};
  wire [7:0] altVal = {dataBusEnableOut, queueState, busClock, lowByteStrobe, rwSignal,
                       2'b00};
  wire [7:0] dirEff = dir_r & DIR_MASK;
  wire busInUse = !isSingle;
  wire busClockFall = busClockPrev_r && !busClock;
  wire tagNxt = busClockFall && isSpecial && isExp && assign_r[BIT_STROBE_EN] && tagEnable &&
                !pinLevel_r[3];

  // Configuration registers; the assignment register loads its mode value after reset.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      initDone_r      <= 1'b0;
      dir_r           <= DIR_RST;
      assign_r        <= ASSIGN_RST_NX;
      pull_r          <= PULL_RST;
      drive_r         <= DRIVE_RST;
      assignWritten_r <= 1'b0;
      driveWritten_r  <= 1'b0;
    end else if (ce) begin
      initDone_r <= 1'b1;
      if (!initDone_r) begin
        assign_r <= assignRstVal;
      end else if (wrAssign) begin
        assign_r        <= assignWrVal;
        assignWritten_r <= 1'b1;
      end
      if (wrDir) begin
        dir_r <= wd & DIR_MASK;
      end
      if (wrPull) begin
        pull_r <= wd & PULL_MASK;
      end
      if (wrDrive) begin
        drive_r        <= driveWrVal;
        driveWritten_r <= 1'b1;
      end
    end
  end

  // Pin input synchroniser and E-clock edge tracking.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pinMeta_r      <= 8'h00;
      pinLevel_r     <= 8'h00;
      busClockPrev_r <= 1'b0;
      lowByteTag_r   <= 1'b0;
    end else if (ce) begin
      pinMeta_r      <= pinIn;
      pinLevel_r     <= pinMeta_r;
      busClockPrev_r <= busClock;
      lowByteTag_r   <= tagNxt;
    end
  end

  // Per-pin direction, data and pull-up steering.
  for (genvar i = 0; i < 8; i++) begin : g_pin
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        pinOut_r[i]    <= 1'b0;
        pinOe_r[i]     <= 1'b0;
        pinPullup_r[i] <= 1'b0;
      end else if (ce) begin
        pinOut_r[i] <= altSel[i] ? altVal[i] : gpioData[i];
        pinOe_r[i]  <= altSel[i] | dirEff[i];
        pinPullup_r[i] <= PULL_ALWAYS[i] |
                          (PULL_PINS[i] & pull_r[BIT_CTL_PULL] & ~(altSel[i] | dirEff[i]));
      end
    end
  end

  // Port-level pull-ups for the address/data ports.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lowBusPull_r  <= 1'b0;
      highBusPull_r <= 1'b0;
    end else if (ce) begin
      lowBusPull_r  <= pull_r[BIT_LOW_PULL] && !busInUse;
      highBusPull_r <= pull_r[BIT_HIGH_PULL] && !busInUse;
    end
  end

  // AXI4-Lite write channels: address and data accepted in either order.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      awHeld_r  <= 1'b0;
      wHeld_r   <= 1'b0;
      awAddr_r  <= '0;
      wData_r   <= 8'h00;
      wStrb0_r  <= 1'b0;
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
    end else if (ce) begin
      awHeld_r  <= awHeldNxt;
      wHeld_r   <= wHeldNxt;
      awready_r <= initDone_r && !awHeldNxt;
      wready_r  <= initDone_r && !wHeldNxt;
      if (awTake) begin
        awAddr_r <= s_axi_awaddr;
      end
      if (wTake) begin
        wData_r  <= s_axi_wdata[7:0];
        wStrb0_r <= s_axi_wstrb[0];
      end
      if (doWrite) begin
        bvalid_r <= 1'b1;
        bresp_r  <= wrHit ? RESP_OKAY : RESP_DECERR;
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // AXI4-Lite read channel: one read at a time, answered on the same edge that accepts the address.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= RESP_OKAY;
    end else if (ce) begin
      arready_r <= initDone_r && !rvalidNxt;
      rvalid_r  <= rvalidNxt;
      if (arTake) begin
        rdata_r <= {24'h00_0000, rdByte};
        rresp_r <= rdHit ? RESP_OKAY : RESP_DECERR;
      end
    end
  end

  assign pinOut               = pinOut_r;
  assign pinOe                = pinOe_r;
  assign pinPullup            = pinPullup_r;
  assign pinLevel             = pinLevel_r;
  assign lowBusPortPullup     = lowBusPull_r;
  assign highBusPortPullup    = highBusPull_r;
  assign ctlPortWeakDrive     = drive_r[BIT_CTL_WEAK];
  assign lowBusPortWeakDrive  = drive_r[BIT_LOW_WEAK];
  assign highBusPortWeakDrive = drive_r[BIT_HIGH_WEAK];
  assign lowByteTag           = lowByteTag_r;
  assign s_axi_awready        = awready_r;
  assign s_axi_wready         = wready_r;
  assign s_axi_bvalid         = bvalid_r;
  assign s_axi_bresp          = bresp_r;
  assign s_axi_arready        = arready_r;
  assign s_axi_rvalid         = rvalid_r;
  assign s_axi_rdata          = rdata_r;
  assign s_axi_rresp          = rresp_r;

  // Checks on the steering and register behaviour.
  default clocking cb @(posedge clk iff ce);
  endclocking
  default disable iff (rst);

  sequence s_first_write;
    initDone_r && wrAssign && !isSpecial && !assignWritten_r;
  endsequence
  sequence s_later_write;
    initDone_r && wrAssign && !isSpecial && assignWritten_r;
  endsequence

  a_irq_pins_input: assert property (pinOe_r[1:0] == 2'b00)
    else $error("Interrupt pins driven as outputs.");
  a_gpio_dir_follow: assert property (!altSel[2] |=> pinOe_r[2] == $past(dir_r[2]))
    else $error("GPIO pin 2 enable does not follow direction bit.");
  a_alt_override: assert property (initDone_r && altSel[4]
                                   |=> pinOe_r[4] && pinOut_r[4] == $past(busClock))
    else $error("Assigned E clock pin not driven.");
  a_queue_pins: assert property (pipeAct |=> pinOe_r[6:5] == 2'b11 &&
                                 pinOut_r[6:5] == $past(queueState))
    else $error("Queue state not shown on pins 6 and 5.");
  a_eclk_off_exp: assert property (initDone_r && isExp |=> !assign_r[BIT_CLK_PIN_OFF])
    else $error("E-clock-off bit set in expanded mode.");
  a_periph_frozen: assert property (initDone_r && isPeriph |=> $stable(assign_r))
    else $error("Assignment register changed in peripheral mode.");
  a_once_locked: assert property (s_later_write |=> $stable(assign_r[BIT_RW_EN]))
    else $error("Guarded bit changed after its single write.");
  a_once_taken: assert property (s_first_write
                                 |=> assign_r[BIT_RW_EN] == $past(wd[BIT_RW_EN]))
    else $error("First normal-mode write not taken.");
  a_pullup_fixed: assert property (initDone_r |=> pinPullup_r[1] && pinPullup_r[6:4] == 3'b000)
    else $error("Fixed pull-up pattern violated.");
  a_bus_pullup_off: assert property (busInUse |=> !lowBusPull_r && !highBusPull_r)
    else $error("Bus port pull-up active while bus in use.");
  a_tag_pulse: assert property (tagNxt |=> lowByteTag_r ##1 !lowByteTag_r || tagNxt)
    else $error("Low byte tag not raised on E fall.");
  a_dir_unmapped: assert property (doWrite && (wrIdx == IDX_DIR) && !dirMapped
                                   |=> $stable(dir_r) && bresp_r == RESP_DECERR)
    else $error("Unmapped direction register accepted a write.");
endmodule : bcp_port_config
`default_nettype wire

// >>> test/bcp_pin_model.sv
// Pin-side model of the devices that share the control-port pins.
`timescale 1ns/1ps
`default_nettype none
module bcp_pin_model (
  input  wire logic       clk,
  input  wire logic [7:0] pinOut,
  input  wire logic [7:0] pinOe,
  input  wire logic [7:0] pinPullup,
  output logic      [7:0] pinIn
);
  logic [7:0] floatPat_r = 8'h5A;

  always @(posedge clk) begin
    floatPat_r <= ~floatPat_r;
  end

  // A floating pin toggles every cycle, so a stale level never passes for a driven one.
  assign pinIn = (pinOe & pinOut) | (~pinOe & pinPullup) | (~pinOe & ~pinPullup & floatPat_r);
endmodule : bcp_pin_model
`default_nettype wire

// >>> test/bus_control_port_config_tb.sv
// Self-checking bench for the bus-control port configuration block.
`timescale 1ns/1ps
`default_nettype none
module bus_control_port_config_tb;
  import bcp_pkg::*;
  logic        clk = 0, rst = 1, pe = 0, visOn = 0, stretchOn = 0, tagEn = 0;
  logic        dataEn = 0, bclk = 1, lbs = 0, rw = 0;
  bcp_mode_t   mode = BCP_NSC;
  logic [1:0]  qs = 0, bresp, rresp;
  logic [7:0]  gpio = 0, pinIn, pinOut, pinOe, pinPull, pinLevel;
  logic        lbPu, hbPu, ceWd, lbWd, hbWd, tag, awRdy, wRdy, bv, arRdy, rv;
  logic        awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
  logic [3:0]  strb = 4'h1;
  logic [9:0]  awa = 0, ara = 0;
  logic [31:0] wd = 0, rdata, seed = 32'h7830;
  logic [7:0]  idx [4] = '{IDX_DIR, IDX_ASSIGN, IDX_PULL, IDX_DRIVE};
  logic [7:0]  rstv [4] = '{DIR_RST, 8'h00, PULL_RST, DRIVE_RST};
  int          errors = 0, cmp_count = 0;

  always #2.5 clk = ~clk;

  bcp_port_config dut (
    .clk(clk), .rst(rst), .ce(1'b1), .mode(mode), .portEmulation(pe),
    .internalVisibility(visOn), .busClockStretch(stretchOn), .tagEnable(tagEn), .gpioData(gpio),
    .dataBusEnableOut(dataEn), .queueState(qs), .busClock(bclk), .lowByteStrobe(lbs),
    .rwSignal(rw), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .pinPullup(pinPull),
    .pinLevel(pinLevel), .lowBusPortPullup(lbPu), .highBusPortPullup(hbPu),
    .ctlPortWeakDrive(ceWd), .lowBusPortWeakDrive(lbWd), .highBusPortWeakDrive(hbWd),
    .lowByteTag(tag), .s_axi_awvalid(awv), .s_axi_awready(awRdy), .s_axi_awaddr(awa),
    .s_axi_wvalid(wv), .s_axi_wready(wRdy), .s_axi_wdata(wd), .s_axi_wstrb(strb),
    .s_axi_bvalid(bv), .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arv),
    .s_axi_arready(arRdy), .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp)
  );

  bcp_pin_model pins (.clk(clk), .pinOut(pinOut), .pinOe(pinOe), .pinPullup(pinPull),
    .pinIn(pinIn));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic logic [7:0] asnRst(input bcp_mode_t m);
    if (m == BCP_NXN || m == BCP_NXW) return ASSIGN_RST_NX;
    if (m == BCP_NSC || m == BCP_PER) return ASSIGN_RST_SCP;
    return ASSIGN_RST_SP;
  endfunction : asnRst

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: value %h, expected %h", $time, got, exp);
    end
  endtask : chk8

  task automatic chkResp(input logic [1:0] got, input logic [1:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: response %b, expected %b", $time, got, exp);
    end
  endtask : chkResp

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    @(posedge clk);
    {awv, wv, bready} <= 3'b111;
    awa <= {a, 2'b00};
    wd <= {24'h0, d};
    do begin
      @(posedge clk);
      if (awRdy) awv <= 1'b0;
      if (wRdy) wv <= 1'b0;
    end while (bv !== 1'b1);
    bready <= 1'b0;
    chkResp(bresp, er);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er);
    @(posedge clk);
    {arv, rready} <= 2'b11;
    ara <= {a, 2'b00};
    do begin
      @(posedge clk);
      if (arRdy) arv <= 1'b0;
    end while (rv !== 1'b1);
    rready <= 1'b0;
    chk8(rdata[7:0], ed);
    chkResp(rresp, er);
  endtask : rd

  task automatic rstm(input bcp_mode_t m);
    rst <= 1'b1;
    mode <= m;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : rstm

  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_of_test

  initial begin
    #100000;
    errors++;
    end_of_test();
  end

  initial begin
    bcp_mode_t md;
    int        n;
    for (int m = 0; m < 7; m++) begin
      md = bcp_mode_t'(m);
      rstm(md);
      for (int i = 0; i < 4; i++) begin
        if (md == BCP_PER) rd(idx[i], 8'h00, RESP_DECERR);
        else rd(idx[i], (i == 1) ? asnRst(md) : rstv[i], RESP_OKAY);
      end
      if (md == BCP_PER) wr(IDX_ASSIGN, 8'hFF, RESP_DECERR);
    end
    rstm(BCP_NSC);
    for (int k = 0; k < 3; k++) begin
      seed = lfsr(seed);
      gpio <= seed[15:8];
      wr(IDX_DIR, seed[7:0], RESP_OKAY);
      rd(IDX_DIR, seed[7:0] & DIR_MASK, RESP_OKAY);
      repeat (3) @(posedge clk);
      chk8(pinOe, seed[7:0] & DIR_MASK);
      chk8(pinOut & pinOe, seed[15:8] & seed[7:0] & DIR_MASK);
      chk8(pinPull, (PULL_PINS & ~(seed[7:0] & DIR_MASK)) | PULL_ALWAYS);
      chk8({6'h0, pinLevel[1:0]}, 8'h03);
    end
    strb <= 4'h0;
    wr(IDX_DIR, ~seed[7:0], RESP_OKAY);
    strb <= 4'h1;
    rd(IDX_DIR, seed[7:0] & DIR_MASK, RESP_OKAY);
    wr(IDX_PULL, 8'hEF, RESP_OKAY);
    rd(IDX_PULL, 8'h03, RESP_OKAY);
    repeat (3) @(posedge clk);
    chk8({6'h0, lbPu, hbPu}, 8'h03);
    chk8(pinPull, PULL_ALWAYS);
    wr(IDX_ASSIGN, 8'h00, RESP_OKAY);
    wr(IDX_ASSIGN, 8'h90, RESP_OKAY);
    rd(IDX_ASSIGN, 8'h80, RESP_OKAY);
    rstm(BCP_NXW);
    qs <= 2'b10;
    lbs <= 1'b1;
    dataEn <= 1'b1;
    wr(IDX_ASSIGN, 8'hFF, RESP_OKAY);
    rd(IDX_ASSIGN, 8'hAC, RESP_OKAY);
    repeat (3) @(posedge clk);
    chk8(pinOe, 8'h7C);
    chk8(pinOut & 8'h7C, {1'b0, qs, bclk, lbs, rw, 2'b00});
    wr(IDX_ASSIGN, 8'h00, RESP_OKAY);
    rd(IDX_ASSIGN, 8'h2C, RESP_OKAY);
    wr(IDX_PULL, 8'h13, RESP_OKAY);
    repeat (3) @(posedge clk);
    chk8(pinOe, 8'hFC);
    chk8({7'h0, pinOut[7]}, {7'h0, dataEn});
    chk8(pinPull, 8'h03);
    chk8({6'h0, lbPu, hbPu}, 8'h00);
    pe <= 1'b1;
    rd(IDX_DIR, 8'h00, RESP_DECERR);
    pe <= 1'b0;
    wr(IDX_DRIVE, 8'hFF, RESP_OKAY);
    wr(IDX_DRIVE, 8'h00, RESP_OKAY);
    rd(IDX_DRIVE, DRIVE_MASK, RESP_OKAY);
    chk8({5'h0, ceWd, lbWd, hbWd}, 8'h07);
    rd(8'h0F, 8'h00, RESP_DECERR);
    wr(8'h08, 8'h55, RESP_DECERR);
    rstm(BCP_NXN);
    wr(IDX_ASSIGN, 8'h08, RESP_OKAY);
    repeat (3) @(posedge clk);
    chk8(pinOe, 8'h90);
    rstm(BCP_SSC);
    stretchOn <= 1'b1;
    repeat (3) @(posedge clk);
    chk8(pinOe, 8'h80);
    visOn <= 1'b1;
    repeat (3) @(posedge clk);
    chk8(pinOe, 8'h90);
    {visOn, stretchOn} <= 2'b00;
    repeat (3) @(posedge clk);
    chk8(pinOe, 8'h90);
    wr(IDX_ASSIGN, 8'h00, RESP_OKAY);
    rd(IDX_ASSIGN, 8'h2C, RESP_OKAY);
    wr(IDX_ASSIGN, 8'h10, RESP_OKAY);
    rd(IDX_ASSIGN, 8'h10, RESP_OKAY);
    repeat (3) @(posedge clk);
    chk8(pinOe, 8'h80);
    rstm(BCP_SXW);
    tagEn <= 1'b1;
    lbs <= 1'b0;
    repeat (4) @(posedge clk);
    bclk <= 1'b0;
    n = 0;
    repeat (8) begin
      @(posedge clk);
      n += (tag === 1'b1);
    end
    chk8(n[7:0], 8'h01);
    end_of_test();
  end
endmodule : bus_control_port_config_tb
`default_nettype wire
